// ---- logic/gdio_map.vh ----
`ifndef GDIO_MAP_VH
`define GDIO_MAP_VH

// Port geometry
`define GDIO_NUM_PORTS      4
`define GDIO_PORT_W         8
`define GDIO_PINS           32
`define GDIO_PORT_IDX_W     2

// Avalon-MM slave geometry
`define GDIO_ADDR_W         8
`define GDIO_DATA_W         32
`define GDIO_BE_W           4

// Byte address fields: port in [6:5], register kind in [4:2]
`define GDIO_ADDR_PORT_MSB  6
`define GDIO_ADDR_PORT_LSB  5
`define GDIO_ADDR_KIND_MSB  4
`define GDIO_ADDR_KIND_LSB  2
`define GDIO_ADDR_TOP_BIT   7
`define GDIO_ALIGN_MASK     8'h03
`define GDIO_CTRL_ADDR      8'h80

// Register kinds within one port window (stride 0x20)
`define GDIO_KIND_INPUT     3'h0
`define GDIO_KIND_DIR       3'h1
`define GDIO_KIND_OUT       3'h2
`define GDIO_KIND_DIR_SET   3'h3
`define GDIO_KIND_DIR_CLR   3'h4
`define GDIO_KIND_OUT_SET   3'h5
`define GDIO_KIND_OUT_CLR   3'h6
`define GDIO_KIND_CTRL      3'h7

// Decode word layout: valid, port, kind
`define GDIO_DEC_W          6
`define GDIO_DEC_VALID      5
`define GDIO_DEC_PORT_MSB   4
`define GDIO_DEC_PORT_LSB   3
`define GDIO_DEC_KIND_MSB   2
`define GDIO_DEC_KIND_LSB   0

// Control register fields and reset values
`define GDIO_PUD_BIT        0
`define GDIO_RST_BYTE       8'h00
`define GDIO_RST_PINS       32'h00000000
`define GDIO_RST_WORD       32'h00000000
`define GDIO_ZERO_PAD       24'h000000

`endif

// ---- logic/gdio_in_sync.v ----
`timescale 1ns/1ps
`include "gdio_map.vh"

// Input path of one port: clamp, clock-high latch, then input register
module gdio_in_sync (
    input  wire                    ref_clk,
    input  wire                    rst_n,
    input  wire                    sleep_clamp,
    input  wire [`GDIO_PORT_W-1:0] pad_in,
    output reg  [`GDIO_PORT_W-1:0] level_r
);

    reg  [`GDIO_PORT_W-1:0] sync_lat;
    wire [`GDIO_PORT_W-1:0] clamped;

    // Sleep clamp holds the input low so floating pins draw no current
    assign clamped = sleep_clamp ? `GDIO_RST_BYTE : pad_in;

    // RULE14 latch closes low
    // Holding the value from the falling edge matches a clock-high latch
    // and avoids a race with the rising-edge stage below
    always @(negedge ref_clk) begin
        sync_lat <= clamped;
    end

    // RULE14 input register stage
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            level_r <= `GDIO_RST_BYTE;
        end else begin
            level_r <= sync_lat;
        end
    end

endmodule

// ---- logic/gdio_port.v ----
// The implementer's own choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`include "gdio_map.vh"

// Functional notes
// RULE1 - Each port has output, direction and read-only input registers.
// RULE2 - Writing one to an input bit flips its output bit; zero is ignored.
// RULE3 - The global pull-up disable turns off every pull-up of every port.
// RULE4 - Direction one makes a pin an output, zero an input with driver off.
// RULE5 - An input pin with output value one has its pull-up on, else off.
// RULE6 - All pins float as soon as reset is asserted, even without a clock.
// RULE7 - An output pin is driven to the level of its output-value bit.
// RULE8 - Direction and output bits can be set or cleared one pin at a time.
// RULE9 - Hi-z input to output high goes via pull-up input or output low.
// RULE10 - Pull-up input to output low goes via hi-z input or output high.
// RULE11 - The pull-up is on only for direction 0, output 1 and disable 0.
// RULE12 - An alternate function on some pins leaves the others plain I/O.
// RULE13 - Strobes are per port; clock, clamp and pull-up disable are shared.
// RULE14 - Inputs pass a clock-high latch and a flop: 0.5 to 1.5 clocks late.
// RULE15 - Registers are 8 bits, bit n is pin n; direction and output reset 0.
module gdio_port (
    input  wire                    ref_clk,
    input  wire                    rst_n,
    input  wire [`GDIO_ADDR_W-1:0] avs_address,
    input  wire                    avs_read,
    input  wire                    avs_write,
    input  wire [`GDIO_DATA_W-1:0] avs_writedata,
    input  wire [`GDIO_BE_W-1:0]   avs_byteenable,
    output reg  [`GDIO_DATA_W-1:0] avs_readdata,
    output reg                     avs_waitrequest,
    input  wire                    sleep_clamp,
    input  wire [`GDIO_PINS-1:0]   pad_in,
    output reg  [`GDIO_PINS-1:0]   pad_out,
    output reg  [`GDIO_PINS-1:0]   pad_oe_n,
    output reg  [`GDIO_PINS-1:0]   pullup_en,
    input  wire [`GDIO_PINS-1:0]   alt_en,
    input  wire [`GDIO_PINS-1:0]   alt_drive_en,
    input  wire [`GDIO_PINS-1:0]   alt_drive_val,
    output reg                     global_pullup_disable
);

    // Register state
    reg  [`GDIO_PINS-1:0]      port_direction_reg_r;
    reg  [`GDIO_PINS-1:0]      port_direction_reg_nxt;
    reg  [`GDIO_PINS-1:0]      port_output_value_reg_r;
    reg  [`GDIO_PINS-1:0]      port_output_value_reg_nxt;
    reg                        pud_nxt;
    wire [`GDIO_PINS-1:0]      port_input_level_reg;

    // Bus decode
    wire [`GDIO_DEC_W-1:0]     dec;
    wire                       dec_valid;
    wire [`GDIO_PORT_IDX_W-1:0] dec_port;
    wire [2:0]                 dec_kind;
    wire                       req;
    wire                       commit_wr;
    wire [`GDIO_PORT_W-1:0]    wbyte;
    reg  [`GDIO_DATA_W-1:0]    rd_val;

    // Per-pin effective controls
    wire [`GDIO_PINS-1:0]      eff_oe;
    wire [`GDIO_PINS-1:0]      eff_val;
    wire [`GDIO_PINS-1:0]      eff_pu;

    // Address decode shared by the read mux and the write path
    function [`GDIO_DEC_W-1:0] gdio_decode;
        input [`GDIO_ADDR_W-1:0] a;
        reg   [2:0]              k;
        begin
            k = a[`GDIO_ADDR_KIND_MSB:`GDIO_ADDR_KIND_LSB];
            gdio_decode = {`GDIO_DEC_W{1'b0}};
            if (a == `GDIO_CTRL_ADDR) begin
                gdio_decode = {1'b1, 2'h0, `GDIO_KIND_CTRL};
            end else if ((a & `GDIO_ALIGN_MASK) != 8'h00) begin
                gdio_decode = {`GDIO_DEC_W{1'b0}};
            end else if (a[`GDIO_ADDR_TOP_BIT]) begin
                gdio_decode = {`GDIO_DEC_W{1'b0}};
            end else if (k == `GDIO_KIND_CTRL) begin
                gdio_decode = {`GDIO_DEC_W{1'b0}};
            end else begin
                gdio_decode = {1'b1,
                    a[`GDIO_ADDR_PORT_MSB:`GDIO_ADDR_PORT_LSB], k};
            end
        end
    endfunction

    assign dec       = gdio_decode(avs_address);
    assign dec_valid = dec[`GDIO_DEC_VALID];
    assign dec_port  = dec[`GDIO_DEC_PORT_MSB:`GDIO_DEC_PORT_LSB];
    assign dec_kind  = dec[`GDIO_DEC_KIND_MSB:`GDIO_DEC_KIND_LSB];
    assign req       = avs_read | avs_write;
    assign wbyte     = avs_writedata[`GDIO_PORT_W-1:0];

    // Write commits on the edge where the master sees waitrequest low
    assign commit_wr = avs_write & ~avs_waitrequest & avs_byteenable[0] &
                       dec_valid;

    // Bus handshake: one wait cycle, then a one-cycle acknowledge
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= `GDIO_RST_WORD;
        end else if (req && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
            avs_readdata    <= rd_val;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    // Read mux; unmapped addresses read as zero
    always @* begin
        rd_val = `GDIO_RST_WORD;
        if (!dec_valid) begin
            rd_val = `GDIO_RST_WORD;
        end else if (dec_kind == `GDIO_KIND_CTRL) begin
            rd_val = {`GDIO_ZERO_PAD, 7'h00, global_pullup_disable};
        // RULE1 input level readback
        end else if (dec_kind == `GDIO_KIND_INPUT) begin
            rd_val = {`GDIO_ZERO_PAD,
                port_input_level_reg[dec_port*`GDIO_PORT_W +: `GDIO_PORT_W]};
        end else if (dec_kind == `GDIO_KIND_DIR ||
                     dec_kind == `GDIO_KIND_DIR_SET ||
                     dec_kind == `GDIO_KIND_DIR_CLR) begin
            rd_val = {`GDIO_ZERO_PAD,
                port_direction_reg_r[dec_port*`GDIO_PORT_W +:
                                     `GDIO_PORT_W]};
        end else begin
            rd_val = {`GDIO_ZERO_PAD,
                port_output_value_reg_r[dec_port*`GDIO_PORT_W +:
                                        `GDIO_PORT_W]};
        end
    end

    // Next-state of direction, output value and pull-up disable
    always @* begin
        port_direction_reg_nxt    = port_direction_reg_r;
        port_output_value_reg_nxt = port_output_value_reg_r;
        pud_nxt                   = global_pullup_disable;
        if (commit_wr) begin
            case (dec_kind)
                // RULE2 toggle on one
                `GDIO_KIND_INPUT: begin
                    port_output_value_reg_nxt[dec_port*`GDIO_PORT_W +:
                        `GDIO_PORT_W] = port_output_value_reg_r[
                        dec_port*`GDIO_PORT_W +: `GDIO_PORT_W] ^ wbyte;
                end
                // RULE1 full byte writes
                `GDIO_KIND_DIR: begin
                    port_direction_reg_nxt[dec_port*`GDIO_PORT_W +:
                        `GDIO_PORT_W] = wbyte;
                end
                `GDIO_KIND_OUT: begin
                    port_output_value_reg_nxt[dec_port*`GDIO_PORT_W +:
                        `GDIO_PORT_W] = wbyte;
                end
                // RULE8 single-bit set
                `GDIO_KIND_DIR_SET: begin
                    port_direction_reg_nxt[dec_port*`GDIO_PORT_W +:
                        `GDIO_PORT_W] = port_direction_reg_r[
                        dec_port*`GDIO_PORT_W +: `GDIO_PORT_W] | wbyte;
                end
                // RULE8 single-bit clear
                `GDIO_KIND_DIR_CLR: begin
                    port_direction_reg_nxt[dec_port*`GDIO_PORT_W +:
                        `GDIO_PORT_W] = port_direction_reg_r[
                        dec_port*`GDIO_PORT_W +: `GDIO_PORT_W] & ~wbyte;
                end
                `GDIO_KIND_OUT_SET: begin
                    port_output_value_reg_nxt[dec_port*`GDIO_PORT_W +:
                        `GDIO_PORT_W] = port_output_value_reg_r[
                        dec_port*`GDIO_PORT_W +: `GDIO_PORT_W] | wbyte;
                end
                `GDIO_KIND_OUT_CLR: begin
                    port_output_value_reg_nxt[dec_port*`GDIO_PORT_W +:
                        `GDIO_PORT_W] = port_output_value_reg_r[
                        dec_port*`GDIO_PORT_W +: `GDIO_PORT_W] & ~wbyte;
                end
                // RULE13 shared pull-up disable
                `GDIO_KIND_CTRL: begin
                    pud_nxt = wbyte[`GDIO_PUD_BIT];
                end
                default: begin
                    pud_nxt = global_pullup_disable;
                end
            endcase
        end
    end

    // RULE15 zero at reset
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            port_direction_reg_r    <= `GDIO_RST_PINS;
            port_output_value_reg_r <= `GDIO_RST_PINS;
            global_pullup_disable   <= 1'b0;
        end else begin
            port_direction_reg_r    <= port_direction_reg_nxt;
            port_output_value_reg_r <= port_output_value_reg_nxt;
            global_pullup_disable   <= pud_nxt;
        end
    end

    genvar gp;
    genvar gn;

    // RULE14 one synchroniser per port
    generate
        for (gp = 0; gp < `GDIO_NUM_PORTS; gp = gp + 1) begin : g_port
            gdio_in_sync u_sync (
                .ref_clk     (ref_clk),
                .rst_n       (rst_n),
                .sleep_clamp (sleep_clamp),
                .pad_in      (pad_in[gp*`GDIO_PORT_W +: `GDIO_PORT_W]),
                .level_r     (port_input_level_reg[gp*`GDIO_PORT_W +:
                                                   `GDIO_PORT_W])
            );
        end
    endgenerate

    // Per-pin controls with alternate-function override
    generate
        for (gn = 0; gn < `GDIO_PINS; gn = gn + 1) begin : g_pin
            // RULE12 override only where enabled
            // RULE4 direction selects driver
            assign eff_oe[gn]  = alt_en[gn] ? alt_drive_en[gn]
                                            : port_direction_reg_r[gn];
            // RULE7 drive output value
            assign eff_val[gn] = alt_en[gn] ? alt_drive_val[gn]
                                            : port_output_value_reg_r[gn];
            // RULE11 pull-up condition
            // RULE5 input with value one
            // RULE3 global disable
            assign eff_pu[gn]  = ~alt_en[gn] &
                                 ~port_direction_reg_r[gn] &
                                 port_output_value_reg_r[gn] &
                                 ~global_pullup_disable;
        end
    endgenerate

    // RULE6 asynchronous release to hi-z
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pad_oe_n  <= {`GDIO_PINS{1'b1}};
            pad_out   <= `GDIO_RST_PINS;
            pullup_en <= `GDIO_RST_PINS;
        end else begin
            pad_oe_n  <= ~eff_oe;
            pad_out   <= eff_val;
            pullup_en <= eff_pu;
        end
    end

endmodule

// ---- verif/gdio_pin_model.sv ----
`timescale 1ns/1ps
// Pin-side circuit: device driver, outside source, pull-up or float
module gdio_pin_model (
    input  wire        ref_clk,
    input  wire [31:0] pad_out,
    input  wire [31:0] pad_oe_n,
    input  wire [31:0] pullup_en,
    input  wire [31:0] ext_en,
    input  wire [31:0] ext_val,
    output wire [31:0] pad_in
);
    reg [31:0] float_r = 32'h55555555;
    // Undriven pins flip every clock so a stale value never reads
    always @(posedge ref_clk) begin
        float_r <= ~float_r;
    end
    // Device driver wins, then outside source, then pull-up
    assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & ext_en & ext_val)
        | (pad_oe_n & ~ext_en & (pullup_en | float_r));
endmodule

// ---- verif/gdio_port_sva.sv ----
`timescale 1ns/1ps
// Handshake and pad control checks at the block ports
module gdio_port_chk (
    input wire        ref_clk,
    input wire        rst_n,
    input wire [7:0]  avs_address,
    input wire        avs_read,
    input wire        avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0]  avs_byteenable,
    input wire [31:0] avs_readdata,
    input wire        avs_waitrequest,
    input wire [31:0] pad_oe_n,
    input wire [31:0] pullup_en,
    input wire        global_pullup_disable
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire ctrl_wr = avs_write && !avs_waitrequest && avs_byteenable[0]
        && avs_address == 8'h80 && avs_writedata[0];
    // Pads float and pull-ups drop while reset is low
    property p_rst_hiz;
        disable iff (1'b0) !rst_n |-> &pad_oe_n && pullup_en == 32'h0;
    endproperty
    a_rst_hiz: assert property (p_rst_hiz)
        else $error("pins driven during reset");
    property p_rst_rel;
        $rose(rst_n) |-> &pad_oe_n && pullup_en == 32'h0;
    endproperty
    a_rst_rel: assert property (p_rst_rel)
        else $error("pins not idle after reset");
    property p_pu_in; (pullup_en & ~pad_oe_n) == 32'h0; endproperty
    a_pu_in: assert property (p_pu_in)
        else $error("pull-up on a driven pin");
    property p_pud;
        global_pullup_disable && $past(global_pullup_disable)
            |-> pullup_en == 32'h0;
    endproperty
    a_pud: assert property (p_pud)
        else $error("pull-up on while disabled");
    property p_pud_src;
        $rose(global_pullup_disable) |-> $past(ctrl_wr) || $past(ctrl_wr, 2);
    endproperty
    a_pud_src: assert property (p_pud_src)
        else $error("pull-up disable set without write");
    property p_ack;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_ack: assert property (p_ack)
        else $error("request not answered");
    property p_ack_one; !avs_waitrequest |=> avs_waitrequest; endproperty
    a_ack_one: assert property (p_ack_one)
        else $error("answer longer than one cycle");
    property p_rd_hold; avs_waitrequest |-> $stable(avs_readdata); endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data moved while waiting");
    property p_rd_hi;
        !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000;
    endproperty
    a_rd_hi: assert property (p_rd_hi)
        else $error("read data upper bits set");
endmodule
bind gdio_port gdio_port_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pad_oe_n(pad_oe_n),
    .pullup_en(pullup_en), .global_pullup_disable(global_pullup_disable));

// ---- verif/gdio_port_tb_top.sv ----
`timescale 1ns/1ps
// Register-level tests of the port block against a pin model
module gdio_port_tb_top;
    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b1;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic        sleep_clamp = 1'b0;
    logic        pud_m = 1'b0;
    logic        avs_waitrequest, global_pullup_disable;
    logic [3:0]  avs_byteenable = 4'hF;
    logic [7:0]  avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h0, alt_en = 32'h0;
    logic [31:0] alt_drive_en = 32'h0, alt_drive_val = 32'h0;
    logic [31:0] ext_en = 32'h0, ext_val = 32'h0, dir_m = 32'h0;
    logic [31:0] out_m = 32'h0, q, avs_readdata, pad_in, pad_out;
    logic [31:0] pad_oe_n, pullup_en;
    int          err_total = 0, cmp_count = 0;
    // Clock
    always #12.5 ref_clk = ~ref_clk;
    gdio_port u_dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .sleep_clamp(sleep_clamp),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
        .pullup_en(pullup_en), .alt_en(alt_en), .alt_drive_en(alt_drive_en),
        .alt_drive_val(alt_drive_val),
        .global_pullup_disable(global_pullup_disable));
    gdio_pin_model u_pins (.ref_clk(ref_clk), .pad_out(pad_out),
        .pad_oe_n(pad_oe_n), .pullup_en(pullup_en), .ext_en(ext_en),
        .ext_val(ext_val), .pad_in(pad_in));
    task finish_test;
        $display("mismatches %0d comparisons %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: %h vs %h", $time, seen, exp);
        end
    endtask
    // One bus transfer, held until waitrequest is seen low
    task bus(input logic is_rd, input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge ref_clk);
        avs_read <= is_rd;
        avs_write <= !is_rd;
        avs_address <= a;
        avs_writedata <= {24'h000000, d};
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 40);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            err_total++;
            finish_test();
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b0, a, d);
        repeat (2) @(posedge ref_clk);
        #1;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        bus(1'b1, a, 8'h00);
        chk(q, {24'h000000, e});
    endtask
    // Expected pad controls from the register model
    task pins;
        logic [31:0] oe;
        logic [31:0] drv;
        oe = ~((alt_en & alt_drive_en) | (~alt_en & dir_m));
        drv = (alt_en & alt_drive_val) | (~alt_en & out_m);
        chk(pad_oe_n, oe);
        chk(pad_out & ~oe, drv & ~oe);
        chk(pullup_en, ~alt_en & ~dir_m & out_m & {32{~pud_m}});
        chk({31'h0, global_pullup_disable}, {31'h0, pud_m});
    endtask
    initial begin
        // Falling reset at time zero floats the pads before any edge
        rst_n <= 1'b0;
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        #1;
        pins;
        for (int p = 0; p < 4; p++) begin
            rd(8'(32 * p + 4), 8'h00);
            rd(8'(32 * p + 8), 8'h00);
        end
        for (int p = 0; p < 4; p++) begin
            wr(8'(32 * p + 4), 8'hF0);
            dir_m[8 * p +: 8] = 8'hF0;
            wr(8'(32 * p + 8), 8'h3C + 8'(p));
            out_m[8 * p +: 8] = 8'h3C + 8'(p);
            pins;
            rd(8'(32 * p + 4), 8'hF0);
            rd(8'(32 * p + 8), 8'h3C + 8'(p));
        end
        wr(8'h2C, 8'h01);
        wr(8'h38, 8'h04);
        wr(8'h34, 8'h80);
        wr(8'h30, 8'h10);
        dir_m[15:8] = 8'hE1;
        out_m[15:8] = 8'hB9;
        pins;
        rd(8'h30, 8'hE1);
        rd(8'h38, 8'hB9);
        wr(8'h40, 8'h0F);
        out_m[23:16] = 8'h31;
        pins;
        rd(8'h48, 8'h31);
        wr(8'h80, 8'h01);
        pud_m = 1'b1;
        pins;
        rd(8'h80, 8'h01);
        wr(8'h80, 8'h00);
        pud_m = 1'b0;
        pins;
        // Refused accesses leave state alone
        @(posedge ref_clk);
        avs_byteenable <= 4'h0;
        wr(8'h08, 8'hFF);
        @(posedge ref_clk);
        avs_byteenable <= 4'hF;
        wr(8'h84, 8'hFF);
        rd(8'h08, 8'h3C);
        rd(8'h84, 8'h00);
        rd(8'h02, 8'h00);
        ext_en <= 32'h0F000000;
        ext_val <= 32'h0A000000;
        repeat (3) @(posedge ref_clk);
        rd(8'h60, 8'h3A);
        sleep_clamp <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rd(8'h60, 8'h00);
        sleep_clamp <= 1'b0;
        alt_en <= 32'h00000008;
        alt_drive_en <= 32'h00000008;
        alt_drive_val <= 32'h00000008;
        repeat (3) @(posedge ref_clk);
        #1;
        pins;
        @(posedge ref_clk);
        alt_en <= 32'h0;
        // pull-up to output low via tri-state
        wr(8'h18, 8'h04);
        wr(8'h0C, 8'h04);
        out_m[2] = 1'b0;
        dir_m[2] = 1'b1;
        pins;
        // pins float without a clock edge
        @(posedge ref_clk);
        #5;
        rst_n <= 1'b0;
        #2;
        chk(pad_oe_n, 32'hFFFFFFFF);
        chk(pullup_en, 32'h0);
        finish_test();
    end
endmodule
